// file: core/hop_pkg.sv
// Contract
// - controller sends clock, data, strobe lines
// - word sent MSB first, lands top
// - strobe with LSB ends 40-bit word
// - bit 39 picks RF path B
// - bit 38 low applies at once
// - bit 38 high waits for trigger
// - controller sets bit 32, list mode
// - controller drives bits 37..33 zero
// - bits 31..0 are the list index
package hop_pkg;
	// =====================================================
	// word layout
	localparam int WORD_W        = 40;
	localparam int PATH_BIT      = 39;
	localparam int IMM_N_BIT     = 38;
	localparam int CMD_HI        = 37;
	localparam int CMD_LO        = 32;
	localparam int CMD_W         = 6;
	localparam int INDEX_W       = 32;
	localparam logic [CMD_W-1:0] LIST_CMD = 6'h01;
	localparam logic [5:0] LAST_BIT_NUM = 6'h27;

	// =====================================================
	// controller register map (byte addresses)
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] INDEX_OFS  = 8'h04;
	localparam logic [7:0] HEAD_OFS   = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;
	localparam int CTRL_SEND_BIT   = 0;
	localparam int HEAD_IMM_N_BIT  = 0;
	localparam int HEAD_PATH_BIT   = 1;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_SENT_BIT   = 1;
	localparam logic [31:0] INDEX_RST = 32'h0000_0000;
	localparam logic [1:0]  HEAD_RST  = 2'h0;

	// =====================================================
	// timing
	localparam int SYS_CLK_MHZ   = 50;
	localparam int LINK_HALF_NS  = 40;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] HALF_LAST = 8'(LINK_HALF_CYC - 1);

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_LOW,
		TX_HIGH
	} tx_state_t;
endpackage

// file: core/hop_link_if.sv
`timescale 1ns/1ns
interface hop_link_if;
	logic hop_clk;
	logic hop_data;
	logic hop_word_end_marker;

	modport ctrl (
		output hop_clk,
		output hop_data,
		output hop_word_end_marker
	);
	modport dev (
		input hop_clk,
		input hop_data,
		input hop_word_end_marker
	);
endinterface

// file: core/hop_sync2.sv
`timescale 1ns/1ns
module hop_sync2 (
	input  wire logic clk_i,
	input  wire logic d_i,
	output logic      q_o
);
	// =====================================================
	// two-stage synchroniser; first stage feeds only the second
	logic meta_reg;
	logic sync_reg;

	always_ff @(posedge clk_i) begin
		meta_reg <= d_i;
		sync_reg <= meta_reg;
	end

	assign q_o = sync_reg;
endmodule

// file: core/hop_cmd_receiver.sv
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module hop_cmd_receiver
	import hop_pkg::*;
(
	input  wire logic               sys_clk_i,
	input  wire logic               srst_i,
	input  wire logic               ce_i,
	hop_link_if.dev                 link,
	input  wire logic               trigger_i,
	output logic                    path_b_o,
	output logic [INDEX_W-1:0]      list_index_o,
	output logic [CMD_W-1:0]        cmd_o,
	output logic                    applied_o,
	output logic                    pending_o,
	output logic                    cmd_error_o,
	output logic [15:0]             word_count_o
);
	// =====================================================
	// link domain reset
	// the link clock may stand still, so reset reaches it through a synchroniser
	logic link_rst;

	hop_sync2 u_rst_sync (
		.clk_i (link.hop_clk),
		.d_i   (srst_i),
		.q_o   (link_rst)
	);

	// =====================================================
	// link domain shifter
	logic [WORD_W-1:0] shift_reg;
	logic [WORD_W-1:0] word_reg;
	logic [WORD_W-1:0] shift_next;
	logic              word_tog_reg;

	assign shift_next = {shift_reg[WORD_W-2:0], link.hop_data};

	always_ff @(posedge link.hop_clk) begin
		if (link_rst) begin
			shift_reg <= '0;
		end else begin
			shift_reg <= shift_next;
		end
	end

	// word is held until the next strobe, 40 link clocks later at least,
	// which leaves the system side ample time to copy it
	always_ff @(posedge link.hop_clk) begin
		if (link_rst) begin
			word_reg     <= '0;
			word_tog_reg <= 1'b0;
		end else if (link.hop_word_end_marker) begin
			word_reg     <= shift_next;
			word_tog_reg <= ~word_tog_reg;
		end
	end

	// =====================================================
	// crossing to the system clock
	logic tog_sync;
	logic tog_seen_reg;
	logic trig_sync;
	logic trig_seen_reg;
	logic new_word;
	logic trig_rise;

	hop_sync2 u_tog_sync (
		.clk_i (sys_clk_i),
		.d_i   (word_tog_reg),
		.q_o   (tog_sync)
	);

	hop_sync2 u_trig_sync (
		.clk_i (sys_clk_i),
		.d_i   (trigger_i),
		.q_o   (trig_sync)
	);

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			tog_seen_reg  <= 1'b0;
			trig_seen_reg <= 1'b0;
		end else if (ce_i) begin
			tog_seen_reg  <= tog_sync;
			trig_seen_reg <= trig_sync;
		end
	end

	assign new_word  = tog_sync ^ tog_seen_reg;
	assign trig_rise = trig_sync & ~trig_seen_reg;

	// =====================================================
	// decode
	logic                 w_path;
	logic                 w_imm_n;
	logic [CMD_W-1:0]     w_cmd;
	logic [INDEX_W-1:0]   w_index;

	assign w_path  = word_reg[PATH_BIT];
	assign w_imm_n = word_reg[IMM_N_BIT];
	assign w_cmd   = word_reg[CMD_HI:CMD_LO];
	assign w_index = word_reg[INDEX_W-1:0];

	// =====================================================
	// held settings for triggered mode
	logic                 hold_path_reg;
	logic [CMD_W-1:0]     hold_cmd_reg;
	logic [INDEX_W-1:0]   hold_index_reg;
	logic                 pending_reg;

	// a newer triggered word replaces the one still waiting
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			hold_path_reg  <= 1'b0;
			hold_cmd_reg   <= '0;
			hold_index_reg <= '0;
		end else if (ce_i && new_word && w_imm_n) begin
			hold_path_reg  <= w_path;
			hold_cmd_reg   <= w_cmd;
			hold_index_reg <= w_index;
		end
	end

	// a word arriving with a trigger wins over that trigger
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pending_reg <= 1'b0;
		end else if (ce_i) begin
			if (new_word) begin
				pending_reg <= w_imm_n;
			end else if (trig_rise) begin
				pending_reg <= 1'b0;
			end
		end
	end

	// =====================================================
	// applied settings
	logic                 path_reg;
	logic [CMD_W-1:0]     cmd_reg;
	logic [INDEX_W-1:0]   index_reg;
	logic                 applied_reg;
	logic                 cmd_err_reg;
	logic [15:0]          count_reg;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			path_reg    <= 1'b0;
			cmd_reg     <= '0;
			index_reg   <= '0;
			applied_reg <= 1'b0;
		end else if (ce_i) begin
			applied_reg <= 1'b0;
			if (new_word && !w_imm_n) begin
				path_reg    <= w_path;
				cmd_reg     <= w_cmd;
				index_reg   <= w_index;
				applied_reg <= 1'b1;
			end else if (!new_word && trig_rise && pending_reg) begin
				path_reg    <= hold_path_reg;
				cmd_reg     <= hold_cmd_reg;
				index_reg   <= hold_index_reg;
				applied_reg <= 1'b1;
			end
		end
	end

	// a word with an unknown function code still goes through; this flag
	// lets software notice a controller that breaks the code layout
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cmd_err_reg <= 1'b0;
		end else if (ce_i && new_word) begin
			cmd_err_reg <= (w_cmd != LIST_CMD);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			count_reg <= '0;
		end else if (ce_i && new_word) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	assign path_b_o     = path_reg;
	assign list_index_o = index_reg;
	assign cmd_o        = cmd_reg;
	assign applied_o    = applied_reg;
	assign pending_o    = pending_reg;
	assign cmd_error_o  = cmd_err_reg;
	assign word_count_o = count_reg;
endmodule

// file: core/hop_cmd_sender.sv
`timescale 1ns/1ns
module hop_cmd_sender
	import hop_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic        ce_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	hop_link_if.ctrl         link
);
	// =====================================================
	// apb slave, one wait-free access phase
	logic              pready_reg;
	logic              pslverr_reg;
	logic [31:0]       prdata_reg;
	logic [INDEX_W-1:0] index_reg;
	logic [1:0]        head_reg;
	logic              busy_reg;
	logic              sent_reg;
	logic              wr_en;
	logic              mapped;
	logic              send_req;
	logic              last_step;

	assign mapped = (paddr_i == CTRL_OFS) || (paddr_i == INDEX_OFS) ||
	                (paddr_i == HEAD_OFS) || (paddr_i == STATUS_OFS);
	assign wr_en  = psel_i && penable_i && pready_reg && pwrite_i && mapped;
	assign send_req = wr_en && (paddr_i == CTRL_OFS) && pwdata_i[CTRL_SEND_BIT] && !busy_reg;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
		end else if (ce_i) begin
			pready_reg  <= psel_i && !penable_i;
			pslverr_reg <= psel_i && !penable_i && !mapped;
			prdata_reg  <= '0;
			if (psel_i && !penable_i && !pwrite_i) begin
				case (paddr_i)
					INDEX_OFS: prdata_reg <= index_reg;
					HEAD_OFS: prdata_reg <= 32'(head_reg);
					STATUS_OFS: begin
						prdata_reg[STAT_BUSY_BIT] <= busy_reg;
						prdata_reg[STAT_SENT_BIT] <= sent_reg;
					end
					default: prdata_reg <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			index_reg <= INDEX_RST;
			head_reg  <= HEAD_RST;
		end else if (ce_i && wr_en) begin
			if (paddr_i == INDEX_OFS) begin
				index_reg <= pwdata_i;
			end
			if (paddr_i == HEAD_OFS) begin
				head_reg <= pwdata_i[1:0];
			end
		end
	end

	// sent flag: write 1 clears, a finishing word in the same cycle wins
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			sent_reg <= 1'b0;
		end else if (ce_i) begin
			if (last_step) begin
				sent_reg <= 1'b1;
			end else if (wr_en && (paddr_i == STATUS_OFS) && pwdata_i[STAT_SENT_BIT]) begin
				sent_reg <= 1'b0;
			end
		end
	end

	// =====================================================
	// serialiser; link clock made by dividing the system clock
	tx_state_t          state_reg;
	logic [7:0]         div_reg;
	logic [WORD_W-1:0]  sh_reg;
	logic [5:0]         bit_reg;
	logic               clk_reg;
	logic               data_reg;
	logic               end_reg;
	logic               half_done;
	logic [WORD_W-1:0]  word;

	// function code is fixed: list mode with reserved bits zero
	assign word = {head_reg[HEAD_PATH_BIT], head_reg[HEAD_IMM_N_BIT], LIST_CMD, index_reg};
	assign half_done = (div_reg == HALF_LAST);
	assign last_step = (state_reg == TX_HIGH) && half_done && (bit_reg == '0);

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state_reg <= TX_IDLE;
			div_reg   <= '0;
			sh_reg    <= '0;
			bit_reg   <= '0;
			clk_reg   <= 1'b0;
			data_reg  <= 1'b0;
			end_reg   <= 1'b0;
			busy_reg  <= 1'b0;
		end else if (ce_i) begin
			div_reg <= half_done ? 8'h00 : div_reg + 8'h01;
			case (state_reg)
				TX_IDLE: begin
					div_reg <= '0;
					if (send_req) begin
						sh_reg    <= word;
						data_reg  <= word[WORD_W-1];
						bit_reg   <= LAST_BIT_NUM;
						busy_reg  <= 1'b1;
						state_reg <= TX_LOW;
					end
				end
				TX_LOW: begin
					if (half_done) begin
						clk_reg   <= 1'b1;
						state_reg <= TX_HIGH;
					end
				end
				TX_HIGH: begin
					if (half_done) begin
						clk_reg <= 1'b0;
						if (bit_reg == '0) begin
							data_reg  <= 1'b0;
							end_reg   <= 1'b0;
							busy_reg  <= 1'b0;
							state_reg <= TX_IDLE;
						end else begin
							sh_reg    <= {sh_reg[WORD_W-2:0], 1'b0};
							data_reg  <= sh_reg[WORD_W-2];
							end_reg   <= (bit_reg == 6'h01);
							bit_reg   <= bit_reg - 6'h01;
							state_reg <= TX_LOW;
						end
					end
				end
				default: state_reg <= TX_IDLE;
			endcase
		end
	end

	assign prdata_o  = prdata_reg;
	assign pready_o  = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign link.hop_clk             = clk_reg;
	assign link.hop_data            = data_reg;
	assign link.hop_word_end_marker = end_reg;
endmodule

// file: verification/hop_link_asserts.sv
`timescale 1ns/1ns
module hop_link_checker (
	input wire logic	sys_clk_i,
	input wire logic	srst_i,
	input wire logic	hop_clk,
	input wire logic	hop_data,
	input wire logic	hop_word_end_marker,
	input wire logic	trigger_i,
	input wire logic	applied_o,
	input wire logic	pending_o
);
	// ==========
	// helpers: link clock rise and bit position
	// the link clock is divided from this clock, so sampling it here is safe
	logic		clk_q;
	logic		imm_q;
	logic [5:0]	pos;
	wire		rise = hop_clk & ~clk_q;
	always_ff @(posedge sys_clk_i) clk_q <= hop_clk;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) pos <= 6'h00;
		else if (rise) pos <= hop_word_end_marker ? 6'h00 : pos + 6'h01;
	end
	always_ff @(posedge sys_clk_i) if (rise && pos == 6'h01) imm_q <= hop_data;
	// ==========
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	sequence word_end;
		rise && hop_word_end_marker;
	endsequence
	sequence marker_bit;
		hop_word_end_marker [*4] ##1 !hop_word_end_marker;
	endsequence
	data_hold_a: assert property (hop_clk && $past(hop_clk) |-> $stable(hop_data))
		else $error("data moved");
	marker_width_a: assert property ($rose(hop_word_end_marker) |-> marker_bit)
		else $error("marker width");
	word_length_a: assert property (word_end |-> pos == 6'h27)
		else $error("word length");
	list_code_a: assert property (rise && pos == 6'h07 |-> hop_data)
		else $error("list bit low");
	reserved_zero_a: assert property (rise && pos > 6'h01 && pos < 6'h07 |-> !hop_data)
		else $error("reserved bit set");
	apply_now_a: assert property (word_end ##0 !imm_q |-> ##[1:8] applied_o)
		else $error("no apply");
	apply_held_a: assert property (word_end ##0 imm_q |-> (!applied_o throughout ##[1:8] pending_o))
		else $error("held word");
	trigger_apply_a: assert property ($rose(trigger_i) && pending_o |-> ##[1:8] applied_o)
		else $error("trigger lost");
endmodule

// file: verification/serial_hop_command_receiver_bench.sv
`timescale 1ns/1ns
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin bad_count++; $display("BAD %s %h %h", nm, e, s); end end
module serial_hop_command_receiver_bench;
	import hop_pkg::*;
	logic sys_clk_i = 0, srst_i = 1, rx_rst = 1, ce = 1, trig = 0, er, path_b, applied, pending, err_b, err_a;
	logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [5:0] cmd;
	logic [31:0] pwdata = 32'h0, prdata, rd, idx, idx_t, seed = 32'h62;
	logic [32:0] e_a;
	logic [39:0] shift;
	logic [32:0] aq[$];
	logic [39:0] wq[$];
	logic [39:0] w_e;
	logic [15:0] cnt_a;
	logic [5:0] cmd_tab[3] = '{6'h3e, 6'h00, 6'h01};
	int bad_count = 0, n_checks = 0, n_words = 0;
	hop_link_if link_a();
	hop_link_if link_b();
	hop_cmd_sender hop_cmd_sender_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .link(link_a));
	hop_cmd_receiver hop_cmd_receiver_inst (.sys_clk_i(sys_clk_i), .srst_i(rx_rst), .ce_i(ce), .link(link_a),
		.trigger_i(trig), .path_b_o(path_b), .list_index_o(idx), .cmd_o(cmd), .applied_o(applied),
		.pending_o(pending), .cmd_error_o(err_a), .word_count_o(cnt_a));
	hop_cmd_receiver hop_cmd_receiver_inst_b (.sys_clk_i(sys_clk_i), .srst_i(rx_rst), .ce_i(ce), .link(link_b),
		.trigger_i(1'b0), .path_b_o(), .list_index_o(), .cmd_o(), .applied_o(), .pending_o(),
		.cmd_error_o(err_b), .word_count_o());
	hop_link_checker hop_link_checker_inst (.sys_clk_i(sys_clk_i), .srst_i(rx_rst), .hop_clk(link_a.hop_clk),
		.hop_data(link_a.hop_data), .hop_word_end_marker(link_a.hop_word_end_marker), .trigger_i(trig),
		.applied_o(applied), .pending_o(pending));
	// ==========
	// clock, random source, closing
	initial forever #10 sys_clk_i = ~sys_clk_i;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge sys_clk_i);
		bad_count++;
		stop_test();
	end
	// ==========
	// bus master and link driver
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		// request stands until the rising edge that samples pready high
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk_i);
			if (pready === 1'b1) break;
		end
		if (n >= 20) begin
			bad_count++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic go();
		int n;
		apb(1'b1, CTRL_OFS, 32'h1);
		rd = 32'h1;
		for (n = 0; n < 100 && rd[STAT_BUSY_BIT]; n++) apb(1'b0, STATUS_OFS, 32'h0);
		if (n >= 100) begin
			bad_count++;
			stop_test();
		end
		`CHK("sent", 1'b1, rd[STAT_SENT_BIT])
		apb(1'b1, STATUS_OFS, 32'h2);
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK("sent clear", 1'b0, rd[STAT_SENT_BIT])
	endtask
	task automatic send(input logic p, input logic im, input logic [31:0] ix);
		apb(1'b1, INDEX_OFS, ix);
		apb(1'b1, HEAD_OFS, {30'h0, p, im});
		wq.push_back({p, im, LIST_CMD, ix});
		if (!im) aq.push_back({p, ix});
		n_words++;
		go();
	endtask
	// far end of the second link: a 15 ns clock that runs only within frames
	task automatic drive_b(input logic [39:0] w);
		for (int i = 39; i >= 0; i--) begin
			link_b.hop_data = w[i];
			link_b.hop_word_end_marker = (i == 0);
			#7 link_b.hop_clk = 1'b1;
			#8 link_b.hop_clk = 1'b0;
		end
		link_b.hop_data = ~w[0];
		link_b.hop_word_end_marker = 1'b0;
	endtask
	// ==========
	// observers
	always @(posedge link_a.hop_clk) begin
		shift = {shift[38:0], link_a.hop_data};
		if (link_a.hop_word_end_marker && !rx_rst) begin
			w_e = wq.pop_front();
			`CHK("wire word", w_e, shift)
		end
	end
	always @(negedge sys_clk_i) if (applied === 1'b1) begin
		e_a = aq.pop_front();
		`CHK("path", e_a[32], path_b)
		`CHK("index", e_a[31:0], idx)
		`CHK("code", LIST_CMD, cmd)
		`CHK("code error a", 1'b0, err_a)
	end
	// ==========
	// main sequence
	initial begin
		link_b.hop_clk = 1'b0;
		link_b.hop_data = 1'b0;
		link_b.hop_word_end_marker = 1'b0;
		repeat (16) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		// receivers stay in reset through one frame, so their link side sees clock edges
		go();
		drive_b(40'h0);
		rx_rst <= 1'b0;
		apb(1'b0, INDEX_OFS, 32'h0);
		`CHK("index reg", INDEX_RST, rd)
		apb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 33'h100000000, {er, rd})
		// link-side reset only drops after two link clocks: one warm-up frame per link,
		// whose top two bits are lost, so they are sent as zero
		send(1'b0, 1'b0, 32'h0);
		drive_b({2'h0, LIST_CMD, 32'h0});
		send(1'b1, 1'b0, 32'hffff_ffff);
		send(1'b0, 1'b0, 32'h0);
		for (int i = 0; i < 4; i++) send(1'(rnd()), 1'b0, rnd());
		send(1'b0, 1'b1, 32'h1234_5678);
		idx_t = rnd();
		send(1'b1, 1'b1, idx_t);
		repeat (6) @(negedge sys_clk_i);
		`CHK("pending", 1'b1, pending)
		aq.push_back({1'b1, idx_t});
		@(posedge sys_clk_i);
		trig <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		trig <= 1'b0;
		repeat (10) @(negedge sys_clk_i);
		`CHK("pending", 1'b0, pending)
		foreach (cmd_tab[j]) begin
			drive_b({2'h0, cmd_tab[j], rnd()});
			repeat (10) @(negedge sys_clk_i);
			`CHK("code error", cmd_tab[j] != LIST_CMD, err_b)
		end
		`CHK("queue", 1'b1, aq.size() == 0)
		`CHK("word count", 16'(n_words), cnt_a)
		stop_test();
	end
endmodule
